// File: rtl/recovered_clock_select_squelch.sv
// Recovered clock source selection, dividers and automatic squelch
//
// Behaviour
// - a 10G source with pre-divider code 1 and divider code 0 gives line rate over 64, internal only.
// - pre-divider code 2 with divider code 0 stretches every 16th cycle by half a period, internal only.
// - pre-divider code 2 with divider code 4 gives 31.25 MHz with roughly every third cycle stretched.
// - pre-divider code 1 with divider code 4 gives line rate over 320 on any output; source is port plus 6.
// - source code 12 is the first PLL, divider 6 for 125 MHz internal only, divider 1 for 31.25 MHz.
// - source code 21 is the second PLL with the same divider choices.
// - each PLL clock can be driven on its own differential output when the copy select is chosen.
// - with auto squelch enabled for the selected source, loss of signal stops the output.
// - sources 4 to 8 use the 1G receiver squelch enable at index source minus 4.
// - sources 9 and 10 use the 6G receiver squelch enable at index source minus 9.
// - sources 14 to 17 use the 10G squelch enable at index source minus 14.
// - sources 12 and 21 squelch on loss of PLL lock when the matching PLL enable is set.
// - a squelched output stops toggling and parks at whichever level it had.
// - each output divides its source by 4, 5, 8, 16 or 25, or by 1 with code 7; internal outputs also by 1 or 2 with codes 0 and 6.
// - outputs 0 to 3 drive the external pins, each set by its own configuration entry.
`timescale 1ns/10ps
`default_nettype none
module recovered_clock_select_squelch (
  input  wire logic        sys_clk,              // 40 MHz system clock
  input  wire logic        rst_b,                // Asynchronous reset, active low
  input  wire logic        clk_en,               // Freezes all state while low
  input  wire logic [7:0]  reg_addr,             // Register byte address
  input  wire logic [31:0] reg_wdata,            // Write data
  input  wire logic        reg_wr,               // Write strobe
  input  wire logic        reg_rd,               // Read strobe
  output logic      [31:0] reg_rdata,            // Read data, cycle after strobe
  input  wire logic [21:0] src_half_tick,        // Per source half-period pulses
  input  wire logic [21:0] src_los,              // Per source loss of signal
  input  wire logic [1:0]  pll_locked,           // PLL lock indications
  output logic      [3:0]  recov_clock_pin,      // External recovered clocks
  output logic      [3:0]  recov_clock_int,      // Internal recovered clocks
  output logic             pll_diff_clock_out,   // First PLL direct clock
  output logic             pll2_diff_clock_out   // Second PLL direct clock
);

  localparam int NO = recov_clk_pkg::NUM_OUT;
  localparam int NT = recov_clk_pkg::NUM_TENG;

  // Configuration storage
  logic [NO-1:0] recov_out_enable;
  logic [2:0]    recov_out_divider_code [NO];
  logic [4:0]    recov_out_source_code  [NO];
  logic [1:0]    teng_pre_divider_code  [NT];
  logic [NT-1:0] teng_auto_squelch_enable;
  logic [recov_clk_pkg::NUM_ONEG-1:0] onegig_squelch_enable;
  logic [recov_clk_pkg::NUM_SIXG-1:0] sixgig_squelch_enable;
  logic [1:0]    pll_lock_squelch_enable;
  logic [1:0]    pll_out_enable;
  logic [1:0]    pll_out_freq_select;

  // Datapath
  logic [NT-1:0] teng_tick;
  logic [NO-1:0] squelched;
  logic [NO-1:0] run;
  logic [NO-1:0] restart;
  logic [NO-1:0] sel_tick;
  logic [NO-1:0] chan_clk;
  logic [2:0]    last_div [NO];
  logic [4:0]    last_src [NO];
  logic [1:0]    pll_level;

  // Squelch decision for one source code
  function automatic logic squelch_of(input logic [4:0] src, input logic [21:0] los,
                                      input logic [1:0] lock, input logic [4:0] oneg_en,
                                      input logic [1:0] sixg_en, input logic [3:0] teng_en,
                                      input logic [1:0] pll_en);
    logic [4:0] idx;
    idx = 5'h00;
    squelch_of = 1'b0;
    if (src >= recov_clk_pkg::SRC_ONEG_LO && src <= recov_clk_pkg::SRC_ONEG_HI) begin
      idx = src - recov_clk_pkg::SRC_ONEG_LO;
      squelch_of = oneg_en[idx[2:0]] && los[src];
    end else if (src >= recov_clk_pkg::SRC_SIXG_LO && src <= recov_clk_pkg::SRC_SIXG_HI) begin
      idx = src - recov_clk_pkg::SRC_SIXG_LO;
      squelch_of = sixg_en[idx[0]] && los[src];
    end else if (src >= recov_clk_pkg::SRC_TSQ_LO && src <= recov_clk_pkg::SRC_TSQ_HI) begin
      idx = src - recov_clk_pkg::SRC_TSQ_LO;
      squelch_of = teng_en[idx[1:0]] && los[src];
    end else if (src == recov_clk_pkg::SRC_PLL0) begin
      squelch_of = pll_en[0] && !lock[0];
    end else if (src == recov_clk_pkg::SRC_PLL1) begin
      squelch_of = pll_en[1] && !lock[1];
    end
  endfunction

  // Half-period stream for one source code; 10G sources pass their pre-divider
  function automatic logic tick_of(input logic [4:0] src, input logic [21:0] raw,
                                   input logic [3:0] pre);
    logic [4:0] idx;
    idx = src - recov_clk_pkg::SRC_TENG_LO;
    // 10G ports sit at port plus 6
    if (src >= recov_clk_pkg::SRC_TENG_LO && src <= recov_clk_pkg::SRC_TENG_HI) begin
      tick_of = pre[idx[1:0]];
    end else if (src < 5'(recov_clk_pkg::NUM_SRC)) begin
      tick_of = raw[src];
    end else begin
      tick_of = 1'b0;  // Unused codes give no clock
    end
  endfunction

  // Output configuration writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      recov_out_enable <= '0;
      for (int i = 0; i < NO; i++) begin
        recov_out_divider_code[i] <= recov_clk_pkg::DIV_RST;
        recov_out_source_code[i]  <= recov_clk_pkg::SRC_RST;
      end
    end else if (clk_en && reg_wr && reg_addr[7:5] == recov_clk_pkg::OUT_CFG_BASE[7:5]
                 && reg_addr[1:0] == 2'h0) begin
      recov_out_enable[reg_addr[4:2]] <= reg_wdata[recov_clk_pkg::OUT_ENA_BIT];
      recov_out_divider_code[reg_addr[4:2]] <= reg_wdata[recov_clk_pkg::OUT_DIV_LSB +: 3];
      recov_out_source_code[reg_addr[4:2]]  <= reg_wdata[recov_clk_pkg::OUT_SRC_LSB +: 5];
    end
  end

  // 10G configuration writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      teng_auto_squelch_enable <= '0;
      for (int i = 0; i < NT; i++) begin
        teng_pre_divider_code[i] <= recov_clk_pkg::PRE_RST;
      end
    end else if (clk_en && reg_wr && reg_addr[7:4] == recov_clk_pkg::TENG_CFG_BASE[7:4]
                 && reg_addr[1:0] == 2'h0) begin
      teng_pre_divider_code[reg_addr[3:2]] <= reg_wdata[recov_clk_pkg::TENG_PRE_LSB +: 2];
      teng_auto_squelch_enable[reg_addr[3:2]] <= reg_wdata[recov_clk_pkg::TENG_SQ_BIT];
    end
  end

  // Receiver and PLL configuration writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      onegig_squelch_enable   <= '0;
      sixgig_squelch_enable   <= '0;
      pll_lock_squelch_enable <= '0;
      pll_out_enable          <= '0;
      pll_out_freq_select     <= recov_clk_pkg::PSEL_RST;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        recov_clk_pkg::ONEG_CFG_ADDR: begin
          onegig_squelch_enable <= reg_wdata[recov_clk_pkg::NUM_ONEG-1:0];
        end
        recov_clk_pkg::SIXG_CFG_ADDR: begin
          sixgig_squelch_enable <= reg_wdata[recov_clk_pkg::NUM_SIXG-1:0];
        end
        recov_clk_pkg::PLL_CFG_ADDR: begin
          pll_lock_squelch_enable <= reg_wdata[1:0];
        end
        recov_clk_pkg::PLL_OUT_ADDR: begin
          pll_out_enable      <= reg_wdata[recov_clk_pkg::PLL_ENA_LSB +: 2];
          pll_out_freq_select <= reg_wdata[recov_clk_pkg::PLL_SEL_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      // Clearing every idle cycle keeps a stale word from passing as fresh
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr[7:5] == recov_clk_pkg::OUT_CFG_BASE[7:5]) begin
          reg_rdata[recov_clk_pkg::OUT_ENA_BIT] <= recov_out_enable[reg_addr[4:2]];
          reg_rdata[recov_clk_pkg::OUT_DIV_LSB +: 3] <= recov_out_divider_code[reg_addr[4:2]];
          reg_rdata[recov_clk_pkg::OUT_SRC_LSB +: 5] <= recov_out_source_code[reg_addr[4:2]];
        end else if (reg_addr[7:4] == recov_clk_pkg::TENG_CFG_BASE[7:4]) begin
          reg_rdata[recov_clk_pkg::TENG_PRE_LSB +: 2] <= teng_pre_divider_code[reg_addr[3:2]];
          reg_rdata[recov_clk_pkg::TENG_SQ_BIT] <= teng_auto_squelch_enable[reg_addr[3:2]];
        end else begin
          case (reg_addr)
            recov_clk_pkg::ONEG_CFG_ADDR: begin
              reg_rdata[recov_clk_pkg::NUM_ONEG-1:0] <= onegig_squelch_enable;
            end
            recov_clk_pkg::SIXG_CFG_ADDR: begin
              reg_rdata[recov_clk_pkg::NUM_SIXG-1:0] <= sixgig_squelch_enable;
            end
            recov_clk_pkg::PLL_CFG_ADDR: begin
              reg_rdata[1:0] <= pll_lock_squelch_enable;
            end
            recov_clk_pkg::PLL_OUT_ADDR: begin
              reg_rdata[recov_clk_pkg::PLL_ENA_LSB +: 2] <= pll_out_enable;
              reg_rdata[recov_clk_pkg::PLL_SEL_LSB +: 2] <= pll_out_freq_select;
            end
            recov_clk_pkg::STATUS_ADDR: begin
              reg_rdata[recov_clk_pkg::STAT_SQ_LSB +: 8] <= squelched;
              reg_rdata[recov_clk_pkg::STAT_LK_LSB +: 2] <= pll_locked;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // one pre-divider per 10G receiver, indexed by source minus 13
  // Every receiver keeps its phase even while no output selects it
  genvar t;
  generate
    for (t = 0; t < NT; t++) begin : g_teng
      teng_pre_divider u_pre (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .half_tick (src_half_tick[recov_clk_pkg::SRC_TENG_LO + t]),
        .pre_code  (teng_pre_divider_code[t]),
        .out_tick  (teng_tick[t])
      );
    end
  endgenerate

  // Remember the last source and divider to spot a reconfiguration
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NO; i++) begin
        last_div[i] <= recov_clk_pkg::DIV_RST;
        last_src[i] <= recov_clk_pkg::SRC_RST;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NO; i++) begin
        last_div[i] <= recov_out_divider_code[i];
        last_src[i] <= recov_out_source_code[i];
      end
    end
  end

  genvar n;
  generate
    for (n = 0; n < NO; n++) begin : g_out
      assign squelched[n] = squelch_of(recov_out_source_code[n], src_los, pll_locked,
                                       onegig_squelch_enable, sixgig_squelch_enable,
                                       teng_auto_squelch_enable, pll_lock_squelch_enable);
      // source selection, PLLs at codes 12 and 21
      assign sel_tick[n] = tick_of(recov_out_source_code[n], src_half_tick, teng_tick);
      // A restart keeps the level, so no half period comes out short
      assign restart[n]  = (last_div[n] != recov_out_divider_code[n])
                           || (last_src[n] != recov_out_source_code[n]);
      // disabled, squelched or barred outputs hold still
      if (n < recov_clk_pkg::NUM_EXT) begin : g_ext
        // divider codes 0 and 6 are barred from external pins; code 7 still divides by 1 there
        assign run[n] = recov_out_enable[n] && !squelched[n]
                        && recov_out_divider_code[n] != recov_clk_pkg::DIV_CODE_BYPASS
                        && recov_out_divider_code[n] != recov_clk_pkg::DIV_CODE_HALF;
      end else begin : g_int
        // stretched 10G streams may use any divider
        assign run[n] = recov_out_enable[n] && !squelched[n];
      end
      recov_out_channel u_chan (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .run       (run[n]),
        .restart   (restart[n]),
        .half_tick (sel_tick[n]),
        .div_code  (recov_out_divider_code[n]),
        .clk_out   (chan_clk[n])
      );
    end
  endgenerate

  // first four drive the pins, the rest stay internal
  assign recov_clock_pin = chan_clk[recov_clk_pkg::NUM_EXT-1:0];
  assign recov_clock_int = chan_clk[NO-1:recov_clk_pkg::NUM_EXT];

  // PLL direct outputs follow each PLL half period when copy select is chosen
  // Enable bits alone do nothing; the select must read copy as well
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_level <= 2'h0;
    end else if (clk_en && pll_out_freq_select == recov_clk_pkg::PLL_SEL_COPY) begin
      if (pll_out_enable[0] && src_half_tick[recov_clk_pkg::SRC_PLL0]) begin
        pll_level[0] <= ~pll_level[0];
      end
      if (pll_out_enable[1] && src_half_tick[recov_clk_pkg::SRC_PLL1]) begin
        pll_level[1] <= ~pll_level[1];
      end
    end
  end

  assign pll_diff_clock_out  = pll_level[0];
  assign pll2_diff_clock_out = pll_level[1];

endmodule
`default_nettype wire

// File: common/recov_clk_pkg.sv
// Constants, register map and decoding shared by the recovered clock selector
package recov_clk_pkg;

  // Block dimensions
  localparam int NUM_OUT  = 8;   // Recovered clock outputs, 0..3 external, 4..7 internal
  localparam int NUM_EXT  = 4;
  localparam int NUM_SRC  = 22;  // Source codes 0..21
  localparam int NUM_TENG = 4;   // 10G receivers
  localparam int NUM_ONEG = 5;   // 1G receivers
  localparam int NUM_SIXG = 2;   // 6G receivers

  // Register byte addresses
  localparam logic [7:0] OUT_CFG_BASE  = 8'h00;  // recov_out_cfg[0..7], one word each
  localparam logic [7:0] TENG_CFG_BASE = 8'h20;  // teng_recov_cfg[0..3]
  localparam logic [7:0] ONEG_CFG_ADDR = 8'h30;  // onegig_receiver_common_cfg
  localparam logic [7:0] SIXG_CFG_ADDR = 8'h34;  // sixgig_receiver_common_cfg
  localparam logic [7:0] PLL_CFG_ADDR  = 8'h38;  // pll_recov_cfg
  localparam logic [7:0] PLL_OUT_ADDR  = 8'h3c;  // pll_output_cfg
  localparam logic [7:0] STATUS_ADDR   = 8'h40;  // Read-only status

  // Field positions
  localparam int OUT_ENA_BIT  = 0;
  localparam int OUT_DIV_LSB  = 4;   // 3 bits
  localparam int OUT_SRC_LSB  = 8;   // 5 bits
  localparam int TENG_PRE_LSB = 0;   // 2 bits
  localparam int TENG_SQ_BIT  = 4;
  localparam int PLL_ENA_LSB  = 0;   // 2 bits, one per PLL output
  localparam int PLL_SEL_LSB  = 4;   // 2 bits
  localparam int STAT_SQ_LSB  = 0;   // 8 bits of squelch state
  localparam int STAT_LK_LSB  = 8;   // 2 bits of PLL lock

  // Values after reset
  localparam logic [2:0] DIV_RST  = 3'h0;
  localparam logic [4:0] SRC_RST  = 5'h00;
  localparam logic [1:0] PRE_RST  = 2'h0;
  localparam logic [1:0] PSEL_RST = 2'h0;

  // Source codes
  localparam logic [4:0] SRC_ONEG_LO = 5'h04;
  localparam logic [4:0] SRC_ONEG_HI = 5'h08;
  localparam logic [4:0] SRC_SIXG_LO = 5'h09;
  localparam logic [4:0] SRC_SIXG_HI = 5'h0a;
  localparam logic [4:0] SRC_PLL0    = 5'h0c;
  localparam logic [4:0] SRC_TENG_LO = 5'h0d;  // Pre-divided sources, port plus 6
  localparam logic [4:0] SRC_TENG_HI = 5'h10;
  localparam logic [4:0] SRC_TSQ_LO  = 5'h0e;  // 10G squelch enable range
  localparam logic [4:0] SRC_TSQ_HI  = 5'h11;
  localparam logic [4:0] SRC_PLL1    = 5'h15;

  // Codes
  localparam logic [2:0] DIV_CODE_BYPASS = 3'h0;  // Internal outputs only
  localparam logic [2:0] DIV_CODE_HALF   = 3'h6;  // Internal outputs only
  localparam logic [1:0] PRE_STRETCH     = 2'h2;
  localparam logic [5:0] STRETCH_LAST    = 6'h20; // 33 half periods per 16 cycles
  localparam logic [1:0] PLL_SEL_COPY    = 2'h1;  // Copy switch core clock

  // Output divider ratio per divider code
  function automatic logic [4:0] div_ratio(input logic [2:0] code);
    case (code)
      3'h0: div_ratio = 5'h01;
      3'h1: div_ratio = 5'h08;
      3'h2: div_ratio = 5'h04;
      3'h3: div_ratio = 5'h10;
      3'h4: div_ratio = 5'h05;
      3'h5: div_ratio = 5'h19;
      3'h6: div_ratio = 5'h02;
      default: div_ratio = 5'h01;
    endcase
  endfunction

endpackage

// File: rtl/teng_pre_divider.sv
// Pre-divider for one 10G receive clock, optionally stretching cycles
`timescale 1ns/10ps
`default_nettype none
module teng_pre_divider (
  input  wire logic       sys_clk,    // System clock
  input  wire logic       rst_b,      // Asynchronous reset, active low
  input  wire logic       clk_en,     // Freezes state while low
  input  wire logic       half_tick,  // One pulse per half period of the receive clock
  input  wire logic [1:0] pre_code,   // teng_pre_divider_code
  output logic            out_tick    // Half-period pulses after pre-division
);

  logic [5:0] phase;

  // Half-period counter; one half period in 33 is swallowed, stretching every 16th cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 6'h00;
    end else if (clk_en && half_tick) begin
      if (phase == recov_clk_pkg::STRETCH_LAST) begin
        phase <= 6'h00;
      end else begin
        phase <= phase + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_tick <= 1'b0;
    end else if (clk_en) begin
      if (pre_code == recov_clk_pkg::PRE_STRETCH) begin
        out_tick <= half_tick && (phase != recov_clk_pkg::STRETCH_LAST);
      end else begin
        out_tick <= half_tick;  // Line rate passes unchanged
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/recov_out_channel.sv
// Output divider for one recovered clock output with glitch-free hold
`timescale 1ns/10ps
`default_nettype none
module recov_out_channel (
  input  wire logic       sys_clk,    // System clock
  input  wire logic       rst_b,      // Asynchronous reset, active low
  input  wire logic       clk_en,     // Freezes state while low
  input  wire logic       run,        // Enabled, allowed and not squelched
  input  wire logic       restart,    // Source or divider changed
  input  wire logic       half_tick,  // Selected source half-period pulses
  input  wire logic [2:0] div_code,   // recov_out_divider_code
  output logic            clk_out     // Recovered clock level
);

  logic [4:0] count;
  logic [4:0] ratio;

  assign ratio = recov_clk_pkg::div_ratio(div_code);

  // toggle every ratio half periods, giving a 50 percent duty even for odd ratios
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 5'h00;
    end else if (clk_en) begin
      if (!run || restart) begin
        count <= 5'h00;
      end else if (half_tick) begin
        count <= (count == ratio - 5'h01) ? 5'h00 : count + 5'h01;
      end
    end
  end

  // level only moves on a full count, so a stop or restart leaves no runt
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_out <= 1'b0;
    end else if (clk_en && run && !restart && half_tick && count == ratio - 5'h01) begin
      clk_out <= ~clk_out;
    end
  end

endmodule
`default_nettype wire

// File: bench/recov_clock_sink.sv
// Far-side clock consumer that counts level changes of every recovered output
`timescale 1ns/10ps
`default_nettype none
module recov_clock_sink (
  input  wire logic        sys_clk,  // Sampling clock
  input  wire logic        clr,      // Clears all counts
  input  wire logic [9:0]  clk_vec,  // Pins, internal, two direct outputs
  output logic [9:0][7:0]  edges     // Level changes seen per output
);
  logic [9:0] last;

  // Count changes; a parked clock adds nothing however long it waits
  always_ff @(posedge sys_clk) begin
    last <= clk_vec;
    for (int i = 0; i < 10; i++) begin
      if (clr) begin
        edges[i] <= 8'h0;
      end else if (clk_vec[i] !== last[i]) begin
        edges[i] <= edges[i] + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/recov_clk_monitor.sv
// Port checker for the recovered clock selector
`timescale 1ns/10ps
`default_nettype none
module recov_clk_monitor (
  input wire logic        sys_clk,             // Clock
  input wire logic        rst_b,               // Reset, active low
  input wire logic        clk_en,              // Run enable
  input wire logic [7:0]  reg_addr,            // Address
  input wire logic        reg_rd,              // Read strobe
  input wire logic [31:0] reg_rdata,           // Read data
  input wire logic [21:0] src_half_tick,       // Source ticks
  input wire logic [1:0]  pll_locked,          // Lock flags
  input wire logic [3:0]  recov_clock_pin,     // External clocks
  input wire logic [3:0]  recov_clock_int,     // Internal clocks
  input wire logic        pll_diff_clock_out,  // First direct clock
  input wire logic        pll2_diff_clock_out  // Second direct clock
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_rdata_idle_zero: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data without a strobe");
  a_unmapped_read_zero: assert property ($past(reg_rd && clk_en && reg_addr > 8'h40) |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_lock_flags: assert property ($past(reg_rd && clk_en && reg_addr == 8'h40)
    |-> reg_rdata[31:8] == {22'h0, $past(pll_locked)})
    else $error("status lock bits wrong");
  a_pll_direct_cause: assert property ($changed(pll_diff_clock_out) |-> $past(src_half_tick[12]))
    else $error("first direct clock moved without tick");
  a_pll2_direct_cause: assert property ($changed(pll2_diff_clock_out) |-> $past(src_half_tick[21]))
    else $error("second direct clock moved without tick");
  // internal toggles need a tick one or two cycles earlier
  a_int_toggle_cause: assert property ($changed(recov_clock_int)
    |-> $past(|src_half_tick) || $past(|src_half_tick, 2))
    else $error("internal clock moved without tick");
  a_pin_toggle_cause: assert property ($changed(recov_clock_pin)
    |-> $past(|src_half_tick) || $past(|src_half_tick, 2))
    else $error("pin clock moved without tick");
  a_freeze_holds_level: assert property (!$past(clk_en)
    |-> $stable(recov_clock_pin) && $stable(recov_clock_int))
    else $error("output moved while frozen");

  c_direct_toggle: cover property ($changed(pll_diff_clock_out));
  c_pin_toggle: cover property ($changed(recov_clock_pin));
  c_read_data: cover property ($past(reg_rd) && reg_rdata != 32'h0);
endmodule

bind recovered_clock_select_squelch recov_clk_monitor u_mon (
  .sys_clk, .rst_b, .clk_en, .reg_addr, .reg_rd, .reg_rdata, .src_half_tick, .pll_locked,
  .recov_clock_pin, .recov_clock_int, .pll_diff_clock_out, .pll2_diff_clock_out
);
`default_nettype wire

// File: bench/recovered_clock_select_squelch_tb.sv
// Self-checking bench for the recovered clock selector
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module recovered_clock_select_squelch_tb;
  logic            sys_clk, rst_b, clk_en, reg_wr, reg_rd, clr, pll_out, pll2_out;
  logic [7:0]      reg_addr;
  logic [31:0]     reg_wdata, reg_rdata, rd_val;
  logic [21:0]     src_half_tick, src_los;
  logic [1:0]      pll_locked;
  logic [3:0]      pin, int_clk;
  logic [9:0][7:0] edges;
  int              err_count, tests_run;
  int unsigned     ratio [8] = '{1, 8, 4, 16, 5, 25, 2, 1};

  recovered_clock_select_squelch DUT (.sys_clk, .rst_b, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .src_half_tick, .src_los, .pll_locked,
    .recov_clock_pin(pin), .recov_clock_int(int_clk),
    .pll_diff_clock_out(pll_out), .pll2_diff_clock_out(pll2_out));
  recov_clock_sink u_sink (.sys_clk, .clr, .clk_vec({pll2_out, pll_out, int_clk, pin}), .edges);

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] cfg(input logic en, input logic [2:0] dv, input logic [4:0] sc);
    cfg = {19'h0, sc, 1'b0, dv, 3'h0, en};
  endfunction

  // Extra edge after each strobe so a following call never reassigns it in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic clear_sink;
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask

  // One half-period pulse every three cycles, then time for the pipeline to drain
  task automatic ticks(input int s, input int n);
    repeat (n) begin
      src_half_tick[s] <= 1'b1;
      @(posedge sys_clk);
      src_half_tick[s] <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic t_regs;
    rd(8'h10, rd_val);
    `CHK("reset config", 32'h0, rd_val)
    wr(8'h10, 32'h0000_0c61);
    rd(8'h10, rd_val);
    `CHK("config readback", 32'h0000_0c61, rd_val)
    rd(8'h80, rd_val);
    `CHK("unmapped read", 32'h0, rd_val)
    pll_locked <= 2'h1;
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, rd_val);
    `CHK("status lock", 32'h100, rd_val & 32'hffff_ff00)
    pll_locked <= 2'h3;
  endtask

  // every divider code, even codes on source 12 and odd codes on source 21
  task automatic t_dividers;
    for (int c = 0; c < 8; c++) begin
      wr(8'h10 + 8'(c % 4 * 4), cfg(1'b1, 3'(c), c[0] ? 5'h15 : 5'h0c));
      wr(8'(c % 4 * 4), cfg(1'b1, 3'(c), c[0] ? 5'h15 : 5'h0c));
      clear_sink();
      ticks(c[0] ? 21 : 12, 2 * ratio[c]);
      `CHK("internal toggles", 8'h2, edges[4 + c % 4])
      `CHK("pin toggles", (c == 0 || c == 6) ? 8'h0 : 8'h2, edges[c % 4])
    end
  endtask

  // pre-divider; 165 ticks hold whole stretch groups of 33
  task automatic t_teng;
    wr(8'h10, cfg(1'b1, 3'h0, 5'h0d));
    wr(8'h14, cfg(1'b1, 3'h4, 5'h0d));
    wr(8'h00, cfg(1'b1, 3'h4, 5'h0d));
    for (int p = 1; p < 3; p++) begin
      wr(8'h20, 32'(p));
      clear_sink();
      ticks(13, 165);
      `CHK("tenG internal", (p == 2) ? 8'ha0 : 8'ha5, edges[4])
      `CHK("tenG div5 int", (p == 2) ? 8'h20 : 8'h21, edges[5])
      `CHK("tenG div5 pin", (p == 2) ? 8'h20 : 8'h21, edges[0])
    end
  endtask

  task automatic t_squelch;
    logic [4:0]  s [5] = '{5'h04, 5'h0a, 5'h0e, 5'h0c, 5'h15};
    logic [7:0]  a [5] = '{8'h30, 8'h34, 8'h20, 8'h38, 8'h38};
    logic [31:0] d [5] = '{32'h1, 32'h2, 32'h10, 32'h1, 32'h2};
    for (int i = 0; i < 5; i++) begin
      wr(8'h10, cfg(1'b1, 3'h6, s[i]));
      wr(a[i], d[i]);
      src_los[s[i]] <= (i < 3);
      pll_locked <= (i == 3) ? 2'h2 : (i == 4) ? 2'h1 : 2'h3;
      clear_sink();
      ticks(s[i], 4);
      `CHK("squelched toggles", 8'h0, edges[4])
      rd(8'h40, rd_val);
      `CHK("squelch status", 1'b1, rd_val[4])
      wr(a[i], 32'h0);
      clear_sink();
      ticks(s[i], 4);
      `CHK("unsquelched toggles", 8'h2, edges[4])
      src_los <= '0;
      pll_locked <= 2'h3;
    end
  endtask

  // direct outputs need the copy select
  task automatic t_direct;
    wr(8'h3c, 32'h13);
    clear_sink();
    ticks(12, 4);
    ticks(21, 3);
    `CHK("pll direct", 8'h4, edges[8])
    `CHK("pll2 direct", 8'h3, edges[9])
    wr(8'h3c, 32'h23);
    clear_sink();
    ticks(12, 4);
    `CHK("pll direct off", 8'h0, edges[8])
  endtask

  task automatic t_hold;
    wr(8'h10, cfg(1'b0, 3'h6, 5'h0c));
    clear_sink();
    ticks(12, 4);
    `CHK("disabled toggles", 8'h0, edges[4])
    wr(8'h10, cfg(1'b1, 3'h6, 5'h0c));
    clk_en <= 1'b0;
    clear_sink();
    ticks(12, 4);
    clk_en <= 1'b1;
    `CHK("frozen toggles", 8'h0, edges[4])
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, src_half_tick, src_los} = '0;
    pll_locked = 2'h3;
    clk_en = 1'b1;
    clr = 1'b1;
    rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    clr <= 1'b0;
    t_regs();
    t_dividers();
    t_teng();
    t_squelch();
    t_direct();
    t_hold();
    final_report();
  end

  // Watchdog well beyond the roughly 1800 cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
